/* File: design/cpu_exec_params.svh */
`ifndef CPU_EXEC_PARAMS_SVH
`define CPU_EXEC_PARAMS_SVH

// register byte addresses on the apb side
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_ACC        8'h08
`define ADDR_INDEX      8'h0C
`define ADDR_STACK      8'h10
`define ADDR_PC         8'h14
`define ADDR_FLAGS      8'h18
`define ADDR_VECTOR     8'h1C

// control and status bit positions
`define CTRL_RUN_BIT    0
`define STAT_RUN_BIT    0
`define STAT_WAIT_BIT   1
`define STAT_ILL_BIT    2

// reset values
`define RST_ACC         8'h00
`define RST_INDEX       16'h0000
`define RST_STACK       16'h00FF
`define RST_PC          16'h0000
`define RST_FLAGS       8'h68
`define RST_VECTOR      16'hFFFC

// flag register bit positions
`define FLAG_V          7
`define FLAG_H          4
`define FLAG_I          3
`define FLAG_N          2
`define FLAG_Z          1
`define FLAG_C          0
`define FLAG_ONES       8'h60

// opcodes handled by this core
`define OP_PREFIX       8'h9E
`define OP_TRAP         8'h83
`define OP_WAIT         8'h8F
`define OP_ACC_TO_FLAGS 8'h84
`define OP_FLAGS_TO_ACC 8'h85
`define OP_STACK_TO_PTR 8'h95
`define OP_PTR_TO_STACK 8'h94
`define OP_ACC_TO_LO    8'h97
`define OP_LO_TO_ACC    8'h9F
`define OP_TEST_DIR     8'h3D
`define OP_TEST_ACC     8'h4D
`define OP_TEST_LO      8'h5D
`define OP_TEST_OFF8    8'h6D
`define OP_TEST_IX      8'h7D
`define OP_TEST_POSTINC 8'h71
`define OP_LOAD_ABS     8'hC6
`define OP_LOAD_OFF16   8'hD6
`define OP_LOAD_OFF8    8'hE6
`define OP_LOAD_IX      8'hF6
`define OP_LOAD_SPOFF   8'hD6
`define OP_TEST_SP1     8'h6D

// count of the last trap push (five pushes, counts 0 to 4)
`define PUSH_LAST       3'd4

`endif

/* File: design/cpu_exec_pkg.sv */
`default_nettype none
package cpu_exec_pkg;
  typedef enum logic [3:0] {
    S_HALT, S_FETCH, S_OPC, S_OB1, S_OB2, S_EXEC, S_PUSH, S_VECH, S_VECL, S_WAIT
  } exec_state_t;

  typedef enum logic [2:0] {
    M_DIR, M_SHORT_IDX, M_IDX, M_POST_INC, M_STACK_SHORT, M_ABS16, M_LONG_IDX, M_STACK_LONG
  } addr_mode_t;
endpackage
`default_nettype wire

/* File: design/zero_sign_test.sv */
`default_nettype none
module zero_sign_test #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] value,
  output logic                  negative,
  output logic                  zero
);
  // value minus zero: no result is kept, only its sign and zero-ness
  assign negative = value[WIDTH-1];
  assign zero     = (value == '0);
endmodule
`default_nettype wire

/* File: design/cpu_exec_core.sv */
// Local design decisions: the placing of the registers and register access over APB.
`include "cpu_exec_params.svh"
`default_nettype none
module cpu_exec_core
  import cpu_exec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        irq_req,
  output logic             wait_active
);

  exec_state_t state_q, state_d;
  addr_mode_t  mode_q, mode_d;
  logic [15:0] pc_q, pc_d, sp_q, sp_d, vec_q, vec_d;
  logic [7:0]  acc_q, acc_d, hi_q, hi_d, lo_q, lo_d, flag_register_q, flag_register_d;
  logic [7:0]  off_hi_q, off_hi_d;
  logic        pre_q, pre_d, load_q, load_d, ill_q, ill_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [15:0] mem_addr_q, mem_addr_d;
  logic        mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d;
  logic [7:0]  mem_wdata_q, mem_wdata_d;
  logic        wait_q, wait_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;

  logic [15:0] index_pair;
  logic [15:0] ea_base, ea_off, ea;
  logic [7:0]  tst_val;
  logic        tst_neg, tst_zero;
  logic        wr_access, halted, addr_ok;

  assign index_pair = {hi_q, lo_q};
  assign halted     = (state_q == S_HALT);
  assign wr_access  = psel && penable && pready_q && pwrite;
  // operand value seen by the sign/zero tester
  assign tst_val = (state_q == S_EXEC) ? mem_rdata :
                   ((mem_rdata == `OP_TEST_LO) ? lo_q : acc_q);

  zero_sign_test #(.WIDTH(8)) u_test (.value(tst_val), .negative(tst_neg), .zero(tst_zero));

  // effective address: base by mode, offset from the bytes just fetched
  always_comb begin
    unique case (mode_q)
      M_SHORT_IDX, M_LONG_IDX, M_IDX, M_POST_INC: ea_base = index_pair;
      M_STACK_SHORT, M_STACK_LONG:                ea_base = sp_q;
      M_DIR, M_ABS16:                             ea_base = 16'h0000;
    endcase
    unique case (mode_q)
      M_ABS16, M_LONG_IDX, M_STACK_LONG: ea_off = {off_hi_q, mem_rdata};
      M_IDX, M_POST_INC:                 ea_off = 16'h0000;
      M_DIR, M_SHORT_IDX, M_STACK_SHORT: ea_off = {8'h00, mem_rdata};
    endcase
    ea = ea_base + ea_off;
  end

  // apb slave: decode in the setup cycle so the access phase always ends at once
  always_comb begin
    prdata_d  = 32'h0000_0000;
    pready_d  = psel && !penable;
    addr_ok   = 1'b1;
    unique case (paddr)
      `ADDR_CTRL:   prdata_d[`CTRL_RUN_BIT] = !halted;
      `ADDR_STATUS: begin
        prdata_d[`STAT_RUN_BIT]  = !halted;
        prdata_d[`STAT_WAIT_BIT] = wait_q;
        prdata_d[`STAT_ILL_BIT]  = ill_q;
      end
      `ADDR_ACC:    prdata_d[7:0]  = acc_q;
      `ADDR_INDEX:  prdata_d[15:0] = index_pair;
      `ADDR_STACK:  prdata_d[15:0] = sp_q;
      `ADDR_PC:     prdata_d[15:0] = pc_q;
      `ADDR_FLAGS:  prdata_d[7:0]  = flag_register_q;
      `ADDR_VECTOR: prdata_d[15:0] = vec_q;
      default:      addr_ok = 1'b0;
    endcase
    pslverr_d = psel && !penable && !addr_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // execution sequencer; cpu registers are only writable over apb while halted
  always_comb begin
    state_d     = state_q;
    mode_d      = mode_q;
    pc_d        = pc_q;
    sp_d        = sp_q;
    vec_d       = vec_q;
    acc_d       = acc_q;
    hi_d        = hi_q;
    lo_d        = lo_q;
    flag_register_d = flag_register_q;
    off_hi_d    = off_hi_q;
    pre_d       = pre_q;
    load_d      = load_q;
    ill_d       = ill_q;
    cnt_d       = cnt_q;
    mem_addr_d  = mem_addr_q;
    mem_rd_d    = 1'b0;
    mem_wr_d    = 1'b0;
    mem_wdata_d = mem_wdata_q;
    wait_d      = wait_q;
    unique case (state_q)
      S_HALT: wait_d = 1'b0;
      S_FETCH: begin
        mem_addr_d = pc_q;
        mem_rd_d   = 1'b1;
        pc_d       = pc_q + 16'h0001; // opcode consumed; trap relies on this advance
        pre_d      = 1'b0;
        state_d    = S_OPC;
      end
      S_OPC: begin
        state_d = S_FETCH;
        load_d  = 1'b0;
        if (!pre_q && mem_rdata == `OP_PREFIX) begin
          mem_addr_d = pc_q;
          mem_rd_d   = 1'b1;
          pc_d       = pc_q + 16'h0001;
          pre_d      = 1'b1;
          state_d    = S_OPC;
        end else if (pre_q) begin
          // prefixed page: stack-relative forms
          mem_addr_d = pc_q;
          mem_rd_d   = 1'b1;
          pc_d       = pc_q + 16'h0001;
          state_d    = S_OB1;
          unique case (mem_rdata)
            `OP_TEST_SP1: mode_d = M_STACK_SHORT;
            `OP_LOAD_SPOFF: begin
              mode_d = M_STACK_LONG;
              load_d = 1'b1;
            end
            default: begin
              ill_d    = 1'b1;
              mem_rd_d = 1'b0;
              pc_d     = pc_q;
              state_d  = S_FETCH;
            end
          endcase
        end else begin
          unique case (mem_rdata)
            `OP_TRAP: begin
              cnt_d   = 3'd0;
              state_d = S_PUSH;
            end
            `OP_WAIT: begin
              flag_register_d[`FLAG_I] = 1'b0;
              wait_d         = 1'b1;
              state_d        = S_WAIT;
            end
            `OP_ACC_TO_FLAGS: flag_register_d = acc_q | `FLAG_ONES;
            `OP_FLAGS_TO_ACC: acc_d = flag_register_q;
            `OP_STACK_TO_PTR: {hi_d, lo_d} = sp_q + 16'h0001;
            `OP_PTR_TO_STACK: sp_d = index_pair - 16'h0001;
            `OP_ACC_TO_LO:    lo_d = acc_q;
            `OP_LO_TO_ACC:    acc_d = lo_q;
            `OP_TEST_ACC, `OP_TEST_LO: begin
              flag_register_d[`FLAG_V] = 1'b0;
              flag_register_d[`FLAG_N] = tst_neg;
              flag_register_d[`FLAG_Z] = tst_zero;
            end
            `OP_TEST_DIR, `OP_TEST_OFF8, `OP_LOAD_ABS, `OP_LOAD_OFF16, `OP_LOAD_OFF8: begin
              mem_addr_d = pc_q;
              mem_rd_d   = 1'b1;
              pc_d       = pc_q + 16'h0001;
              state_d    = S_OB1;
              load_d     = (mem_rdata[7:4] >= 4'hC);
              unique case (mem_rdata)
                `OP_TEST_DIR: mode_d = M_DIR;
                `OP_LOAD_ABS: mode_d = M_ABS16;
                `OP_LOAD_OFF16: mode_d = M_LONG_IDX;
                default:      mode_d = M_SHORT_IDX;
              endcase
            end
            `OP_TEST_IX, `OP_TEST_POSTINC, `OP_LOAD_IX: begin
              mem_addr_d = index_pair;
              mem_rd_d   = 1'b1;
              load_d     = (mem_rdata == `OP_LOAD_IX);
              mode_d     = (mem_rdata == `OP_TEST_POSTINC) ? M_POST_INC : M_IDX;
              state_d    = S_EXEC;
            end
            default: ill_d = 1'b1; // unsupported here: skipped as a one-byte no-op
          endcase
        end
      end
      S_OB1: begin
        if (mode_q == M_ABS16 || mode_q == M_LONG_IDX || mode_q == M_STACK_LONG) begin
          off_hi_d   = mem_rdata; // high byte comes first
          mem_addr_d = pc_q;
          mem_rd_d   = 1'b1;
          pc_d       = pc_q + 16'h0001;
          state_d    = S_OB2;
        end else begin
          mem_addr_d = ea;
          mem_rd_d   = 1'b1;
          state_d    = S_EXEC;
        end
      end
      S_OB2: begin
        mem_addr_d = ea;
        mem_rd_d   = 1'b1;
        state_d    = S_EXEC;
      end
      S_EXEC: begin
        // memory operand is never written back by a test
        if (load_q) acc_d = mem_rdata;
        flag_register_d[`FLAG_V] = 1'b0;
        flag_register_d[`FLAG_N] = tst_neg;
        flag_register_d[`FLAG_Z] = tst_zero;
        if (mode_q == M_POST_INC) {hi_d, lo_d} = index_pair + 16'h0001;
        state_d = S_FETCH;
      end
      S_PUSH: begin
        mem_addr_d = sp_q;
        mem_wr_d   = 1'b1;
        sp_d       = sp_q - 16'h0001;
        cnt_d      = cnt_q + 3'd1;
        unique case (cnt_q)
          3'd0:    mem_wdata_d = pc_q[7:0];
          3'd1:    mem_wdata_d = pc_q[15:8];
          3'd2:    mem_wdata_d = lo_q;
          3'd3:    mem_wdata_d = acc_q;
          default: mem_wdata_d = flag_register_q;
        endcase
        if (cnt_q == `PUSH_LAST) begin
          flag_register_d[`FLAG_I] = 1'b1;
          state_d        = S_VECH;
        end
      end
      S_VECH: begin
        mem_addr_d = vec_q;
        mem_rd_d   = 1'b1;
        state_d    = S_VECL;
      end
      S_VECL: begin
        if (mem_rd_q && mem_addr_q == vec_q) begin
          pc_d[15:8] = mem_rdata;
          mem_addr_d = vec_q + 16'h0001;
          mem_rd_d   = 1'b1;
        end else begin
          pc_d[7:0] = mem_rdata;
          state_d   = S_FETCH;
        end
      end
      S_WAIT: begin
        // nothing advances while waiting; only an interrupt request restarts fetch
        if (irq_req) begin
          wait_d  = 1'b0;
          state_d = S_FETCH;
        end
      end
    endcase
    // software control: start and stop, and register loads while halted
    if (wr_access) begin
      if (paddr == `ADDR_CTRL) begin
        if (pwdata[`CTRL_RUN_BIT] && halted) begin
          state_d = S_FETCH;
          ill_d   = 1'b0;
        end else if (!pwdata[`CTRL_RUN_BIT]) begin
          state_d  = S_HALT;
          mem_rd_d = 1'b0;
          mem_wr_d = 1'b0;
          wait_d   = 1'b0;
        end
      end else if (halted) begin
        unique case (paddr)
          `ADDR_ACC:    acc_d = pwdata[7:0];
          `ADDR_INDEX:  {hi_d, lo_d} = pwdata[15:0];
          `ADDR_STACK:  sp_d = pwdata[15:0];
          `ADDR_PC:     pc_d = pwdata[15:0];
          `ADDR_FLAGS:  flag_register_d = pwdata[7:0] | `FLAG_ONES;
          `ADDR_VECTOR: vec_d = pwdata[15:0];
          default:      ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= S_HALT;
      mode_q      <= M_DIR;
      pc_q        <= `RST_PC;
      sp_q        <= `RST_STACK;
      vec_q       <= `RST_VECTOR;
      acc_q       <= `RST_ACC;
      {hi_q, lo_q} <= `RST_INDEX;
      flag_register_q <= `RST_FLAGS;
      off_hi_q    <= 8'h00;
      pre_q       <= 1'b0;
      load_q      <= 1'b0;
      ill_q       <= 1'b0;
      cnt_q       <= 3'd0;
      mem_addr_q  <= 16'h0000;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
      wait_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      pc_q        <= pc_d;
      sp_q        <= sp_d;
      vec_q       <= vec_d;
      acc_q       <= acc_d;
      hi_q        <= hi_d;
      lo_q        <= lo_d;
      flag_register_q <= flag_register_d;
      off_hi_q    <= off_hi_d;
      pre_q       <= pre_d;
      load_q      <= load_d;
      ill_q       <= ill_d;
      cnt_q       <= cnt_d;
      mem_addr_q  <= mem_addr_d;
      mem_rd_q    <= mem_rd_d;
      mem_wr_q    <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
      wait_q      <= wait_d;
    end
  end

  // every output is a flop
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign mem_addr    = mem_addr_q;
  assign mem_rd      = mem_rd_q;
  assign mem_wr      = mem_wr_q;
  assign mem_wdata   = mem_wdata_q;
  assign wait_active = wait_q;

endmodule
`default_nettype wire

/* File: tb/mem_partner.sv */
`default_nettype none
module mem_partner (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  // async read; off-cycle the bus shows junk so a late sample is caught
  assign rdata = rd ? mem[addr] : ~last;
  // no wait states; the bench preloads programs by hierarchy
  always @(posedge clk) begin
    if (wr) mem[addr] <= wdata;
    if (rd) last <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: tb/cpu_exec_core_asserts.sv */
`default_nettype none
module cpu_exec_core_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic        irq_req,
  input wire logic        wait_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero-wait slave: one answer pulse per setup
  property p_apb_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer missing or long");
  property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("refused access carries data");
  // trap pushes walk the stack downward, five bytes, then two vector reads
  property p_push_down; mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h1; endproperty
  a_push_down: assert property (p_push_down) else $error("push address not decremented");
  property p_push_five; $rose(mem_wr) |-> mem_wr [*5] ##1 !mem_wr; endproperty
  a_push_five: assert property (p_push_five) else $error("push count wrong");
  // the vector high read is already out in the cycle the last push ends
  property p_vec_fetch; $fell(mem_wr) |-> mem_rd ##1 (mem_rd && mem_addr == $past(mem_addr) + 16'h1); endproperty
  a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch wrong");
  // stop entry comes from the wait opcode alone
  property p_wait_entry; $rose(wait_active) |-> $past(mem_rd) && $past(mem_rdata) == 8'h8F; endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("stop without wait opcode");
  property p_wait_hold; wait_active && !irq_req && !psel |=> wait_active; endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("stop left without request");
  property p_wait_quiet; wait_active |-> !mem_rd && !mem_wr; endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("bus activity while stopped");
  property p_wait_leave; wait_active && irq_req |=> !wait_active; endproperty
  a_wait_leave: assert property (p_wait_leave) else $error("request did not wake core");
  c_trap: cover property (mem_wr [*5]);
  c_wait: cover property ($rose(wait_active));
  c_refuse: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: tb/cpu_exec_core_bench.sv */
`include "cpu_exec_params.svh"
`default_nettype none
module cpu_exec_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, irq_req, pready, pslverr;
  logic        mem_rd, mem_wr, wait_active, err;
  logic [7:0]  paddr, mem_wdata, mem_rdata, a, f, d;
  logic [15:0] mem_addr, x, s, k, t;
  logic [31:0] pwdata, prdata, seed, r, v, w;
  logic [39:0] c;
  int          failures, checks, cyc;

  cpu_exec_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .irq_req, .wait_active);
  mem_partner u_mem (.clk(pclk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata), .rdata(mem_rdata));

  always #20 pclk = ~pclk;
  // hang guard: the whole run needs a few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // flags after a test then wait: V clear, I clear, H and C kept
  function automatic logic [15:0] tf(input logic [7:0] g, input logic [7:0] u);
    return {8'h0, 1'h0, 2'h3, g[4], 1'h0, u[7], u == 8'h0, g[0]};
  endfunction
  function automatic logic [15:0] kf(input logic [7:0] g);
    return {8'h0, g[7], 2'h3, g[4], 1'h0, g[2:0]};
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wn, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= wn;
    paddr   <= ad;
    pwdata  <= dt;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'h1, ad, dt);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [15:0] e);
    apb(1'h0, ad, 32'h0);
    chk(r, {16'h0, e});
  endtask
  task automatic wait_stop();
    int n;
    n = 0;
    while (wait_active !== 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, wait_active}, 32'h1);
  endtask
  // every program ends in the wait opcode, which is our stop marker
  task automatic run(input logic [15:0] pc, input logic [39:0] code, input logic hold = 1'h0);
    for (int i = 0; i < 5; i++) u_mem.mem[pc + 16'(i)] = code[39 - 8 * i -: 8];
    wr(`ADDR_ACC, {24'h0, a});
    wr(`ADDR_INDEX, {16'h0, x});
    wr(`ADDR_STACK, {16'h0, s});
    wr(`ADDR_FLAGS, {24'h0, f});
    wr(`ADDR_PC, {16'h0, pc});
    wr(`ADDR_CTRL, 32'h1);
    wait_stop();
    if (!hold) wr(`ADDR_CTRL, 32'h0);
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, irq_req} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 32'hBED0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    // reset state and a refused address
    rd(`ADDR_STACK, 16'h00FF);
    rd(`ADDR_FLAGS, 16'h0068);
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`ADDR_VECTOR, 32'h0300);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      w = rnd();
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : v[7:0];
      f = v[15:8];
      x = {2'h1, v[29:16]};
      s = {8'h02, v[31:24]};
      k = {2'h0, w[21:8]};
      d = w[7:0];
      // zero/sign test on acc, index low and post-increment memory
      run(16'h0100, 40'h4D8F000000);
      rd(`ADDR_FLAGS, tf(f, a));
      rd(`ADDR_ACC, {8'h0, a});
      run(16'h0100, 40'h5D8F000000);
      rd(`ADDR_FLAGS, tf(f, x[7:0]));
      u_mem.mem[x] = d;
      run(16'h0100, 40'h718F000000);
      rd(`ADDR_FLAGS, tf(f, d));
      rd(`ADDR_INDEX, x + 16'h1);
      // each addressing form feeds a load (m < 5) or a memory test
      for (int m = 0; m < 9; m++) begin
        case (m)
          0: {t, c} = {x, 8'hC6, x, 8'h8F, 8'h0};
          1: {t, c} = {x + {8'h0, k[7:0]}, 8'hE6, k[7:0], 8'h8F, 16'h0};
          2: {t, c} = {x + k, 8'hD6, k, 8'h8F, 8'h0};
          3: {t, c} = {s + k, 16'h9ED6, k, 8'h8F};
          4: {t, c} = {x, 40'hF68F000000};
          5: {t, c} = {8'h0, k[7:0], 8'h3D, k[7:0], 24'h8F0000};
          6: {t, c} = {x + {8'h0, k[7:0]}, 8'h6D, k[7:0], 24'h8F0000};
          7: {t, c} = {x, 40'h7D8F000000};
          default: {t, c} = {s + {8'h0, k[7:0]}, 16'h9E6D, k[7:0], 16'h8F00};
        endcase
        u_mem.mem[t] = d;
        run(16'h0100, c);
        if (m < 5) rd(`ADDR_ACC, {8'h0, d});
        else rd(`ADDR_FLAGS, tf(f, d));
      end
      // register transfers
      run(16'h0100, 40'h958F000000);
      rd(`ADDR_INDEX, s + 16'h1);
      rd(`ADDR_FLAGS, kf(f));
      run(16'h0100, 40'h948F000000);
      rd(`ADDR_STACK, x - 16'h1);
      // index low byte moves alone; the high byte must stay put
      run(16'h0100, 40'h9F8F000000);
      rd(`ADDR_ACC, {8'h0, x[7:0]});
      run(16'h0100, 40'h978F000000);
      rd(`ADDR_INDEX, {x[15:8], a});
      run(16'h0100, 40'h84858F0000);
      rd(`ADDR_FLAGS, kf(a));
      rd(`ADDR_ACC, {8'h0, a | 8'h60});
      // trap pushes state, then runs the vector target
      {u_mem.mem[16'h0300], u_mem.mem[16'h0301], u_mem.mem[16'h0400]} = 24'h04008F;
      run(16'h0180, 40'h8300000000);
      chk({u_mem.mem[s], u_mem.mem[s - 16'h1], u_mem.mem[s - 16'h2], u_mem.mem[s - 16'h3]}, {16'h8101, x[7:0], a});
      chk({24'h0, u_mem.mem[s - 16'h4]}, {24'h0, f | 8'h60});
      rd(`ADDR_STACK, s - 16'h5);
    end
    // an opcode outside this core is skipped and flagged in status
    run(16'h0500, 40'h428F000000);
    rd(`ADDR_STATUS, 16'h4);
    // a stopped core ignores time and wakes only on a request
    run(16'h0500, 40'h8F8F000000, 1'h1);
    repeat (20) @(posedge pclk);
    chk({31'h0, wait_active}, 32'h1);
    rd(`ADDR_STATUS, 16'h3);
    irq_req <= 1'h1;
    @(posedge pclk);
    irq_req <= 1'h0;
    #1 chk({31'h0, wait_active}, 32'h0);
    wait_stop();
    wr(`ADDR_CTRL, 32'h0);
    rd(`ADDR_STATUS, 16'h0);
    complete_run();
  end
endmodule

bind cpu_exec_core cpu_exec_core_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .irq_req, .wait_active);
`default_nettype wire
